// [include/rps_pkg.sv]
// ============================================================
// rail power sequencer shared definitions
package rps_pkg;

   // ============================================================
   // rail map
   localparam int RAILS = 10;
   localparam int STROBES = 10;
   localparam int GAPS = 9;
   localparam int SEQ_W = 4;
   localparam int DLY_W = 2;
   localparam int RAIL_BUCK_ONE = 0;
   localparam int RAIL_LINEAR = 4;
   localparam int RAIL_LOAD_SWITCH_ONE = 5;
   localparam int RAIL_LOAD_SWITCH_TWO = 6;
   localparam int RAIL_LOAD_SWITCH_THREE = 7;
   localparam int RAIL_BACKUP_ONE = 8;
   localparam int RAIL_BACKUP_TWO = 9;
   localparam logic [3:0] STROBE_FIRST = 4'h1;
   localparam logic [3:0] STROBE_BACKUP_LAST = 4'h2;
   localparam logic [3:0] STROBE_LAST = 4'ha;
   localparam logic [3:0] STROBE_NONE = 4'h0;

   // ============================================================
   // register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ADDR_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_SEQ_LO = 8'h04;
   localparam logic [7:0] ADDR_SEQ_HI = 8'h08;
   localparam logic [7:0] ADDR_DELAY = 8'h0c;
   localparam logic [7:0] ADDR_CONFIG = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam int CFG_FACTOR_BIT = 0;
   localparam int CFG_SEAL_BIT = 1;
   localparam int CFG_LONG_BIT = 2;
   localparam int CFG_W = 3;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_DIR_LSB = 4;
   localparam int ST_STEP_LSB = 8;
   localparam int ST_BUSY_BIT = 12;
   localparam int ST_PINS_LSB = 16;
   localparam logic [2:0] CFG_RESET = 3'h1;
   // rail9 .. rail0 strobe fields
   localparam logic [39:0] SEQ_RESET = 40'h2100876543;
   localparam logic [17:0] DLY_RESET = 18'h00000;

   // ============================================================
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYCLES_PER_MS = (CLK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam int DLY_MIN_MS = 2;
   localparam int DLY_MAX_MS = 5;
   localparam int DOWN_FACTOR = 10;
   localparam int EXIT_MS = 500;
   localparam int WAIT_TIMEOUT_S = 20;
   localparam int LONG_PRESS_S = 8;
   localparam int LONG_PRESS_ALT_S = 15;
   localparam int WAIT_TIMEOUT_MS = WAIT_TIMEOUT_S * MS_PER_S;
   localparam int LONG_PRESS_MS = LONG_PRESS_S * MS_PER_S;
   localparam int LONG_PRESS_ALT_MS = LONG_PRESS_ALT_S * MS_PER_S;
   localparam int MS_CNT_W = 15;
   localparam int GAP_CNT_W = 8;
   localparam int EXIT_CNT_W = 10;

   // ============================================================
   // types
   typedef enum logic [2:0] {
      st_off = 3'b000,
      st_pre_off = 3'b001,
      awaiting_enable_state = 3'b010,
      st_active = 3'b011,
      st_suspend = 3'b100,
      fault_state_a = 3'b101,
      st_shutdown = 3'b110
   } rps_state_t;

   typedef enum logic [1:0] {
      seq_idle = 2'b00,
      seq_up = 2'b01,
      seq_down = 2'b10
   } rps_dir_t;

   typedef struct packed {
      logic rails_fail;
      logic overtemp;
      logic lockout;
      logic power_enable;
      logic adapter;
      logic push_button;
   } rps_pins_t;

   localparam int PINS_W = 6;
   localparam logic [5:0] PINS_IDLE = 6'h03;

endpackage

// [design/rps_sequencer.sv]
`timescale 1ns/1ns
module rps_sequencer
   import rps_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic push_button_input,
   input wire logic adapter_detect_pin,
   input wire logic power_enable_pin,
   input wire logic supply_lockout,
   input wire logic overtemp_shutdown,
   input wire logic rails_fault,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   output logic [RAILS-1:0] rail_enable_register,
   output logic [RAILS-1:0] rail_discharge,
   output rps_state_t seq_state,
   output logic seq_busy
);

   // ============================================================
   // parameter check
   if (MS_CYCLES < 1 || MS_CYCLES > 16777215) begin : g_bad_ms
      $error("MS_CYCLES out of range");
   end

   // ============================================================
   // reset release
   logic [1:0] rst_sync;
   logic rst_n;

   // bias undervoltage drives resetn: whole core restarts
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ============================================================
   // pin synchronisers
   logic [PINS_W-1:0] pin_raw;
   logic [PINS_W-1:0] pin_s1;
   logic [PINS_W-1:0] pin_s2;
   logic [PINS_W-1:0] pin_s3;
   logic [PINS_W-1:0] pin_filt;
   logic [PINS_W-1:0] pin_prev;
   rps_pins_t pins;
   rps_pins_t prev;

   assign pin_raw = {rails_fault, overtemp_shutdown, supply_lockout,
                     power_enable_pin, adapter_detect_pin,
                     push_button_input};

   for (genvar p = 0; p < PINS_W; p++) begin : g_pin
      // a change is accepted only once stages two and three agree
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pin_s1[p] <= PINS_IDLE[p];
            pin_s2[p] <= PINS_IDLE[p];
            pin_s3[p] <= PINS_IDLE[p];
            pin_filt[p] <= PINS_IDLE[p];
            pin_prev[p] <= PINS_IDLE[p];
         end else begin
            pin_s1[p] <= pin_raw[p];
            pin_s2[p] <= pin_s1[p];
            pin_s3[p] <= pin_s2[p];
            if (pin_s2[p] == pin_s3[p]) begin
               pin_filt[p] <= pin_s3[p];
            end
            pin_prev[p] <= pin_filt[p];
         end
      end
   end

   assign pins = rps_pins_t'(pin_filt);
   assign prev = rps_pins_t'(pin_prev);

   logic press_fall;
   logic ac_fall;
   logic pe_rise;
   logic fault_any;
   logic up_blocked;

   assign press_fall = prev.push_button & ~pins.push_button;
   assign ac_fall = prev.adapter & ~pins.adapter;
   assign pe_rise = ~prev.power_enable & pins.power_enable;
   assign fault_any = pins.lockout | pins.overtemp | pins.rails_fail;
   assign up_blocked = pins.lockout | pins.overtemp;

   // ============================================================
   // millisecond tick
   logic [23:0] pre_cnt;
   logic ms_tick;

   assign ms_tick = (pre_cnt == 24'(MS_CYCLES - 1));

   // one shared tick keeps every long timer narrow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= 24'h000000;
      end else if (ms_tick) begin
         pre_cnt <= 24'h000000;
      end else begin
         pre_cnt <= pre_cnt + 24'h000001;
      end
   end

   // ============================================================
   // registers
   logic [CFG_W-1:0] cfg;
   logic [SEQ_W*RAILS-1:0] seq_cfg;
   logic [DLY_W*GAPS-1:0] dly_cfg;
   logic busy;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= CFG_RESET;
         seq_cfg <= SEQ_RESET;
         dly_cfg <= DLY_RESET;
      end else if (reg_write) begin
         case (reg_addr)
            ADDR_SEQ_LO: seq_cfg[31:0] <= reg_wdata;
            ADDR_SEQ_HI: seq_cfg[39:32] <= reg_wdata[7:0];
            ADDR_DELAY: dly_cfg <= reg_wdata[17:0];
            ADDR_CONFIG: cfg <= reg_wdata[CFG_W-1:0];
            default: ;
         endcase
      end
   end

   // ============================================================
   // timers
   rps_state_t state;
   rps_state_t next_state;
   rps_state_t target;
   rps_state_t next_target;
   logic [MS_CNT_W-1:0] press_ms;
   logic [MS_CNT_W-1:0] wait_ms;
   logic [EXIT_CNT_W-1:0] down_ms;
   logic boot_pending;
   logic boot_evt;
   logic long_press;
   logic wait_expired;
   logic down_done;

   assign long_press = cfg[CFG_LONG_BIT] ?
      (press_ms > MS_CNT_W'(LONG_PRESS_ALT_MS)) :
      (press_ms > MS_CNT_W'(LONG_PRESS_MS));
   assign wait_expired = (wait_ms >= MS_CNT_W'(WAIT_TIMEOUT_MS));
   assign down_done = (down_ms >= EXIT_CNT_W'(EXIT_MS));
   // main supply present with adapter grounded, judged once pins settled
   assign boot_evt = boot_pending & ms_tick & ~pins.adapter;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_pending <= 1'b1;
      end else if (ms_tick) begin
         boot_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         press_ms <= '0;
      end else if (pins.push_button) begin
         press_ms <= '0;
      end else if (ms_tick && press_ms != '1) begin
         press_ms <= press_ms + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ms <= '0;
      end else if (state != awaiting_enable_state) begin
         wait_ms <= '0;
      end else if (ms_tick && !wait_expired) begin
         wait_ms <= wait_ms + 1'b1;
      end
   end

   // the exit clock ignores gap settings so discharge time is fixed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         down_ms <= '0;
      end else if (state != st_shutdown) begin
         down_ms <= '0;
      end else if (ms_tick && !down_done) begin
         down_ms <= down_ms + 1'b1;
      end
   end

   // ============================================================
   // power state machine
   logic start_up;
   logic start_down;
   logic leave_down;

   always_comb begin
      next_state = state;
      next_target = target;
      start_up = 1'b0;
      start_down = 1'b0;
      case (state)
         st_off: begin
            if (!up_blocked &&
                (press_fall || ac_fall || pe_rise || boot_evt)) begin
               start_up = 1'b1;
            end
         end
         st_pre_off: begin
            if (!up_blocked && (press_fall || ac_fall || pe_rise)) begin
               start_up = 1'b1;
            end
         end
         st_suspend: begin
            if (fault_any) begin
               start_down = 1'b1;
               next_target = fault_state_a;
            end else if (long_press) begin
               start_down = 1'b1;
               next_target = st_off;
            end else if (!up_blocked && (press_fall || ac_fall ||
                                         pins.power_enable)) begin
               start_up = 1'b1;
            end
         end
         awaiting_enable_state: begin
            if (fault_any) begin
               start_down = 1'b1;
               next_target = fault_state_a;
            end else if (long_press) begin
               start_down = 1'b1;
               next_target = st_off;
            end else if (pins.power_enable) begin
               next_state = st_active;
            end else if (pins.push_button && pins.adapter &&
                         wait_expired) begin
               start_down = 1'b1;
               next_target = st_off;
            end
         end
         st_active: begin
            // adapter pin has no say here
            if (fault_any) begin
               start_down = 1'b1;
               next_target = fault_state_a;
            end else if (long_press) begin
               start_down = 1'b1;
               next_target = st_off;
            end else if (!pins.power_enable) begin
               start_down = 1'b1;
               next_target = cfg[CFG_SEAL_BIT] ? st_suspend : st_off;
            end
         end
         st_shutdown: begin
            if (down_done) begin
               next_state = target;
            end
         end
         fault_state_a: begin
            if (!fault_any) begin
               next_state = st_pre_off;
            end
         end
         default: begin
            next_state = st_off;
         end
      endcase
      if (start_up) begin
         next_state = awaiting_enable_state;
      end
      if (start_down) begin
         next_state = st_shutdown;
      end
   end

   assign leave_down = (state == st_shutdown) && down_done;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= st_off;
         target <= st_off;
      end else begin
         state <= next_state;
         target <= next_target;
      end
   end

   assign seq_state = state;

   // ============================================================
   // strobe engine
   rps_dir_t dir;
   logic [3:0] step;
   logic first;
   logic [GAP_CNT_W-1:0] gap_ms;
   logic [GAP_CNT_W-1:0] gap_need;
   logic [3:0] gap_idx;
   logic [GAP_CNT_W-1:0] gap_base;
   logic fire;
   logic [3:0] down_last;

   // a sealed backup domain ends the walk at strobe three
   assign down_last = cfg[CFG_SEAL_BIT] ? STROBE_BACKUP_LAST + 4'h1 :
                                          STROBE_FIRST;
   // going up the gap before strobe s is gap s-1; going down it is gap s
   assign gap_idx = (dir == seq_up) ? step - 4'h1 : step;

   always_comb begin
      gap_base = GAP_CNT_W'(DLY_MIN_MS);
      if (gap_idx >= 4'h1 && gap_idx <= 4'(GAPS)) begin
         gap_base = GAP_CNT_W'(DLY_MIN_MS) + GAP_CNT_W'(
            dly_cfg[DLY_W*(gap_idx - 4'h1) +: DLY_W]);
      end
      if (first) begin
         gap_need = '0;
      end else if (dir == seq_down && cfg[CFG_FACTOR_BIT]) begin
         gap_need = GAP_CNT_W'(gap_base * GAP_CNT_W'(DOWN_FACTOR));
      end else begin
         gap_need = gap_base;
      end
   end

   assign fire = (dir != seq_idle) && (gap_ms >= gap_need);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir <= seq_idle;
         step <= STROBE_NONE;
         first <= 1'b0;
         gap_ms <= '0;
      end else if (start_down) begin
         dir <= seq_down;
         step <= STROBE_LAST;
         first <= 1'b1;
         gap_ms <= '0;
      end else if (start_up) begin
         dir <= seq_up;
         step <= STROBE_FIRST;
         first <= 1'b1;
         gap_ms <= '0;
      end else if (leave_down) begin
         dir <= seq_idle;
         step <= STROBE_NONE;
      end else if (fire) begin
         first <= 1'b0;
         gap_ms <= '0;
         if (dir == seq_up) begin
            if (step == STROBE_LAST) begin
               dir <= seq_idle;
            end else begin
               step <= step + 4'h1;
            end
         end else begin
            if (step == down_last) begin
               dir <= seq_idle;
            end else begin
               step <= step - 4'h1;
            end
         end
      end else if (ms_tick && dir != seq_idle && gap_ms != '1) begin
         gap_ms <= gap_ms + 1'b1;
      end
   end

   assign busy = (dir != seq_idle) || (state == st_shutdown);

   // ============================================================
   // rail enables and discharge
   logic sw_enable_wr;

   // enable register is locked while any sequence runs
   assign sw_enable_wr = reg_write && (reg_addr == ADDR_ENABLE) && !busy;

   for (genvar r = 0; r < RAILS; r++) begin : g_rail
      logic [SEQ_W-1:0] field;
      logic sealed;
      logic strobe_ok;
      assign field = seq_cfg[SEQ_W*r +: SEQ_W];
      // only the backup rails may answer strobes one and two
      assign strobe_ok = (field > STROBE_BACKUP_LAST) ||
                         (r >= RAIL_BACKUP_ONE);
      assign sealed = cfg[CFG_SEAL_BIT] && (field <= STROBE_BACKUP_LAST);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            rail_enable_register[r] <= 1'b0;
            rail_discharge[r] <= 1'b1;
         end else if (fire && strobe_ok && field != STROBE_NONE &&
                      field == step) begin
            // strobe zero never matches a step
            rail_enable_register[r] <= (dir == seq_up);
            rail_discharge[r] <= (dir != seq_up);
         end else if (start_down && next_target != st_suspend &&
                      field == STROBE_NONE &&
                      r <= RAIL_LOAD_SWITCH_ONE) begin
            rail_enable_register[r] <= 1'b0;
            rail_discharge[r] <= 1'b1;
         end else if (leave_down && dir == seq_down &&
                      field != STROBE_NONE && field <= step &&
                      !sealed) begin
            // strobes still pending at the 500 ms exit are forced off
            rail_enable_register[r] <= 1'b0;
            rail_discharge[r] <= 1'b1;
         end else if (leave_down && target != st_suspend &&
                      field == STROBE_NONE &&
                      (r == RAIL_LOAD_SWITCH_TWO ||
                       r == RAIL_LOAD_SWITCH_THREE)) begin
            rail_enable_register[r] <= 1'b0;
         end else if (sw_enable_wr) begin
            rail_enable_register[r] <= reg_wdata[r];
            rail_discharge[r] <= ~reg_wdata[r];
         end
         // unsequenced rails are otherwise left alone, also into SUSPEND
      end
   end

   // ============================================================
   // busy flag and read port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_busy <= 1'b0;
      end else begin
         seq_busy <= busy;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         case (reg_addr)
            ADDR_ENABLE: reg_rdata <= DATA_W'(rail_enable_register);
            ADDR_SEQ_LO: reg_rdata <= seq_cfg[31:0];
            ADDR_SEQ_HI: reg_rdata <= DATA_W'(seq_cfg[39:32]);
            ADDR_DELAY: reg_rdata <= DATA_W'(dly_cfg);
            ADDR_CONFIG: reg_rdata <= DATA_W'(cfg);
            ADDR_STATUS: begin
               reg_rdata <= '0;
               reg_rdata[ST_STATE_LSB +: 3] <= state;
               reg_rdata[ST_DIR_LSB +: 2] <= dir;
               reg_rdata[ST_STEP_LSB +: 4] <= step;
               reg_rdata[ST_BUSY_BIT] <= busy;
               reg_rdata[ST_PINS_LSB +: PINS_W] <= pin_filt;
            end
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule // rps_sequencer

// [bench/rps_host_model.sv]
`timescale 1ns/1ns
// ============================================================
// host side: push-button and power-enable pin
module rps_host_model (
   input wire logic clk,
   input wire logic press,
   input wire logic keep_on,
   output logic push_button_input = 1'b1,
   output logic power_enable_pin = 1'b0
);
   // pins move only after an edge, like a host gpio
   always_ff @(posedge clk) begin
      push_button_input <= !press;
      power_enable_pin <= keep_on;
   end
endmodule // rps_host_model

// [bench/rps_sequencer_properties.sv]
`timescale 1ns/1ns
// ============================================================
// port checks
module rps_sequencer_properties
   import rps_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic power_enable_pin,
   input wire logic supply_lockout,
   input wire logic overtemp_shutdown,
   input wire logic rails_fault,
   input wire logic reg_write,
   input wire logic [RAILS-1:0] rail_enable_register,
   input wire logic [RAILS-1:0] rail_discharge,
   input wire rps_state_t seq_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   localparam int DOWN_MAX = (EXIT_MS + 1) * MS_CYCLES + 8;
   localparam int DOWN_MIN = (EXIT_MS - 2) * MS_CYCLES;
   logic [31:0] down_cnt;
   logic quiet;
   assign quiet = !supply_lockout && !overtemp_shutdown && !rails_fault;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) down_cnt <= 32'h0;
      else if (seq_state == st_shutdown) down_cnt <= down_cnt + 32'h1;
      else down_cnt <= 32'h0;
   end
   chk_off_discharges: assert property (((~rail_enable_register &
      $past(rail_enable_register) & ~rail_discharge) & 10'h01f) == 10'h0)
      else $error("rail dropped without discharge");
   chk_exit_not_late: assert property (down_cnt <= DOWN_MAX)
      else $error("power-down overran exit time");
   chk_exit_not_early: assert property (
      $fell(seq_state == st_shutdown)
      |-> $past(down_cnt) >= DOWN_MIN) else $error("power-down left early");
   chk_switch_late_off: assert property (
      $fell(rail_enable_register[RAIL_LOAD_SWITCH_TWO]) && !$past(reg_write)
      |-> ##[0:1] seq_state inside {st_off, fault_state_a})
      else $error("switch two dropped early");
   chk_fault_downs: assert property ((seq_state == st_active &&
      rails_fault) ##1 rails_fault [*6] |-> ##[0:4]
      seq_state inside {st_shutdown, fault_state_a})
      else $error("fault ignored");
   chk_enable_low_downs: assert property ((seq_state == st_active &&
      !power_enable_pin) ##1 !power_enable_pin [*6] |-> ##[0:4]
      seq_state == st_shutdown) else $error("enable low ignored");
   chk_enable_high_on: assert property ((seq_state ==
      awaiting_enable_state && power_enable_pin && quiet) ##1
      (power_enable_pin && quiet) [*6] |-> ##[0:4] seq_state == st_active)
      else $error("enable high ignored");
   chk_off_wakes: assert property ((seq_state == st_off &&
      !power_enable_pin) [*6] ##1 (power_enable_pin && quiet) [*7] |->
      ##[0:4] seq_state inside {awaiting_enable_state, st_active})
      else $error("wake from off missed");
endmodule // rps_sequencer_properties
bind rps_sequencer rps_sequencer_properties #(.MS_CYCLES(MS_CYCLES))
   rps_sequencer_properties_i (.clk(clk), .resetn(resetn),
   .power_enable_pin(power_enable_pin), .supply_lockout(supply_lockout),
   .overtemp_shutdown(overtemp_shutdown), .rails_fault(rails_fault),
   .reg_write(reg_write), .rail_enable_register(rail_enable_register),
   .rail_discharge(rail_discharge), .seq_state(seq_state));

// [bench/rps_sequencer_tb.sv]
`timescale 1ns/1ns
// ============================================================
// bench
module rps_sequencer_tb;
   import rps_pkg::*;
   // short ms tick keeps the 500 ms exits affordable
   localparam int MSC = 10;
   logic clk = 1'b0, resetn = 1'b0, press = 1'b0, keep_on = 1'b0;
   logic adapter = 1'b1, lockout = 1'b0, rails_fault = 1'b0;
   logic reg_write = 1'b0, reg_read = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic btn, pe, seq_busy;
   logic [9:0] en, dis;
   rps_state_t seq_state;
   int fails = 0, comparisons = 0, n;
   rps_host_model rps_host_model_i (.clk(clk), .press(press),
      .keep_on(keep_on), .push_button_input(btn), .power_enable_pin(pe));
   rps_sequencer #(.MS_CYCLES(MSC)) rps_sequencer_i (.clk(clk),
      .resetn(resetn), .push_button_input(btn), .adapter_detect_pin(adapter),
      .power_enable_pin(pe), .supply_lockout(lockout),
      .overtemp_shutdown(1'b0), .rails_fault(rails_fault),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .rail_enable_register(en), .rail_discharge(dis),
      .seq_state(seq_state), .seq_busy(seq_busy));
   task automatic final_report();
      if (fails == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      chk(reg_rdata, e);
   endtask
   task automatic wait_st(input rps_state_t s, input int lim);
      n = 0;
      while (seq_state !== s) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, seq_state, s);
            final_report();
         end
      end
   endtask
   task automatic t_reset();
      repeat (5) @(negedge clk);
      chk({en, dis}, 20'h003ff);
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (MSC * 3) @(posedge clk);
      rd(8'hfc, 32'h0);
   endtask
   task automatic t_press_up();
      @(posedge clk);
      press <= 1'b1;
      wait_st(awaiting_enable_state, 20);
      repeat (3) @(negedge clk);
      chk(32'(en), 32'h100);
      chk(32'(seq_busy), 32'h1);
      wr(ADDR_ENABLE, 32'h0);
      press <= 1'b0;
      repeat (MSC * 30) @(negedge clk);
      chk(32'(en), 32'h33f);
      chk(32'(seq_state), 32'(awaiting_enable_state));
      chk(32'(seq_busy), 32'h0);
   endtask
   task automatic t_active();
      @(posedge clk);
      keep_on <= 1'b1;
      wait_st(st_active, 20);
      wr(ADDR_ENABLE, 32'h3ff);
      rd(ADDR_ENABLE, 32'h3ff);
      wr(ADDR_SEQ_LO, 32'h00876540);
   endtask
   task automatic t_down_off();
      @(posedge clk);
      keep_on <= 1'b0;
      wait_st(st_shutdown, 20);
      repeat (4) @(negedge clk);
      chk(32'(en), 32'h3fe);
      chk(32'(seq_busy), 32'h1);
      repeat (MSC * 30) @(negedge clk);
      chk(32'(en), 32'h3fe);
      wait_st(st_off, 5100);
      chk(32'(n > 4680 && n < 4712), 32'h1);
      chk({en, dis[4:0]}, 15'h001f);
   endtask
   task automatic t_suspend();
      wr(ADDR_CONFIG, 32'h3);
      keep_on <= 1'b1;
      wait_st(st_active, 40);
      repeat (MSC * 30) @(negedge clk);
      wr(ADDR_ENABLE, 32'h3ff);
      keep_on <= 1'b0;
      wait_st(st_suspend, 5100);
      chk(32'(en), 32'h3c1);
      @(posedge clk);
      keep_on <= 1'b1;
      wait_st(st_active, 30);
   endtask
   task automatic t_fault();
      @(posedge clk);
      rails_fault <= 1'b1;
      wait_st(fault_state_a, 5100);
      chk(32'(en), 32'h300);
      @(posedge clk);
      rails_fault <= 1'b0;
      keep_on <= 1'b0;
      wait_st(st_pre_off, 40);
      @(posedge clk);
      lockout <= 1'b1;
      adapter <= 1'b0;
      repeat (20) @(negedge clk);
      chk(32'(seq_state), 32'(st_pre_off));
      @(posedge clk);
      lockout <= 1'b0;
      adapter <= 1'b1;
      repeat (10) @(posedge clk);
      adapter <= 1'b0;
      wait_st(awaiting_enable_state, 20);
   endtask
   initial begin
      forever #50 clk = !clk;
   end
   initial begin
      t_reset();
      t_press_up();
      t_active();
      t_down_off();
      t_suspend();
      t_fault();
      final_report();
   end
endmodule // rps_sequencer_tb
